/* logic/ptt_defs.svh */
// constants for the periodic tick timer: offsets, fields, reset values
// assumes an 8-bit register port with byte addresses as printed
`ifndef PTT_DEFS_SVH
`define PTT_DEFS_SVH
`define PTT_ADDR_W 16
`define PTT_OFF_STATUS 16'h004B
`define PTT_OFF_CNT_HI 16'h004C
`define PTT_OFF_CNT_LO 16'h004D
`define PTT_OFF_WRAP_HI 16'h004E
`define PTT_OFF_WRAP_LO 16'h004F
`define PTT_BIT_OVF 7
`define PTT_BIT_IE 6
`define PTT_BIT_HALT 5
`define PTT_BIT_CLR 4
`define PTT_PS_HI 2
`define PTT_PS_LO 0
`define PTT_WRAP_RESET 16'hFFFF
`define PTT_CNT_RESET 16'h0000
`define PTT_PS_RESET 3'h0
`define PTT_PS_MAX 3'h6
`define PTT_PRE_W 6
`endif

/* logic/ptt_pkg.sv */
// types shared by the periodic tick timer files
// assumes ptt_defs.svh for the numeric constants
package ptt_pkg;
  typedef logic [7:0] ptt_byte_t;
  typedef logic [15:0] ptt_word_t;
  typedef logic [2:0] ptt_ps_t;
  // read latch of the low count byte
  typedef enum logic [0:0] {
    PTT_LATCH_OPEN = 1'b0,
    PTT_LATCH_HELD = 1'b1
  } ptt_latch_t;
endpackage

/* logic/ptt_prescaler.sv */
// prescaler: free 6-bit divider producing one-cycle ticks at clk/2^n
// assumes clk is the internal bus clock; run low freezes the divider
`include "ptt_defs.svh"
`timescale 1ns/1ps
module ptt_prescaler
#(
  parameter int PRE_W = `PTT_PRE_W
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // control
  input wire logic run,
  input wire logic clear,
  input wire ptt_pkg::ptt_ps_t select,
  // tick out
  output logic tick
);
  import ptt_pkg::*;
  typedef struct packed
  {
    logic [PRE_W-1:0] div;
  } ptt_pre_state_t;
  ptt_pre_state_t state;
  ptt_pre_state_t next_state;
  logic [PRE_W:0] mask;
  ptt_ps_t sel_eff;

  // 111 falls back to divide by 64
  always_comb
  begin
    sel_eff = (select > `PTT_PS_MAX) ? `PTT_PS_MAX : select;
    mask = (PRE_W+1)'((1 << sel_eff) - 1);
    tick = run && ((state.div & mask[PRE_W-1:0]) == mask[PRE_W-1:0]);
    next_state = state;
    if (clear)
    begin
      next_state.div = '0;
    end
    else if (run)
    begin
      next_state.div = state.div + 1'b1;
    end
  end

  // divider register
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      state <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end
endmodule

/* logic/ptt_timer.sv */
// periodic tick timer: 16-bit modulo up-counter with overflow interrupt
// assumes a single bus clock, synchronous reset and a one-cycle strobe bus
// What this block does
// - 16-bit up-counter, free running or wrapping at the modulo value.
// - reading the count never disturbs or pauses counting.
// - prescaler gives seven rates; select field picks the counting rate.
// - overflow flag sets on the tick that takes the count from the modulo value back to zero.
// - enabled flag raises interrupt; enable cleared by reset.
// - counter keeps running in wait; interrupt can wake the processor.
// - registers are not accessible while in wait mode.
// - stop mode freezes the timer, registers keep their values.
// - break holds the counter still.
// - in break, the overflow flag clears or arms only when break clear enable is 1; other status bits stay writable.
// - armed clear survives protected break; second step afterward clears.
// - clear flag by status read with flag set, then write 0.
// - overflow between read and write makes the clearing write ignored.
// - writing 1 to the flag does nothing; reset clears it.
// - halt bit stops counting; reset sets it.
// - clear bit zeroes counter and prescaler, self-clears, reads 0.
// - select 000..110 divide 1..64; 111 also 64; reset clears it.
// - at the modulo value the count restarts from zero next tick.
// - high count read latches low byte until low byte read.
// - modulo high write inhibits flag and interrupt until low written.
//
// Implementation choice: the plain strobed port.
`include "ptt_defs.svh"
`timescale 1ns/1ps
module ptt_timer
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // register port
  input wire logic [`PTT_ADDR_W-1:0] addr,
  input wire ptt_pkg::ptt_byte_t wdata,
  input wire logic wr,
  input wire logic rd,
  output ptt_pkg::ptt_byte_t rdata,
  // system state
  input wire logic wait_mode,
  input wire logic stop_mode,
  input wire logic break_active,
  input wire logic break_clear_enable,
  // interrupt
  output logic irq
);
  import ptt_pkg::*;

  typedef struct packed
  {
    ptt_word_t count;
    ptt_word_t wrap;
    ptt_byte_t wrap_hi_buf;
    logic wrap_pending;
    ptt_byte_t low_latch;
    ptt_latch_t latch;
    logic overflow_flag;
    logic clear_armed;
    logic overflow_irq_enable;
    logic counter_halt;
    ptt_ps_t prescale_select;
    ptt_byte_t rdata;
    logic irq;
  } ptt_state_t;

  ptt_state_t state;
  ptt_state_t next_state;
  logic tick;
  logic run;
  logic access;
  logic protect;
  logic clear_req;
  logic hit;
  logic ovf_set;

  // bus is dead in wait; stop and break freeze counting
  assign access = !wait_mode;
  assign run = !state.counter_halt && !stop_mode && !break_active;
  assign protect = break_active && !break_clear_enable;
  assign clear_req = access && wr && (addr == `PTT_OFF_STATUS) && wdata[`PTT_BIT_CLR];

  ptt_prescaler #(.PRE_W(`PTT_PRE_W)) u_pre
  (
    .clk(clk),
    .rstn(rstn),
    .run(run),
    .clear(clear_req),
    .select(state.prescale_select),
    .tick(tick)
  );

  // the modulo compare; wrap of all ones gives free running
  assign hit = tick && !clear_req && (state.count == state.wrap);
  assign ovf_set = hit && !state.wrap_pending;

  // next state
  always_comb
  begin
    next_state = state;
    next_state.rdata = 8'h00;
    // counting; reads are not looked at here so they never disturb it
    if (clear_req)
    begin
      next_state.count = `PTT_CNT_RESET;
    end
    else if (tick)
    begin
      next_state.count = hit ? `PTT_CNT_RESET : state.count + 16'h0001;
    end
    // reads
    if (access && rd)
    begin
      case (addr)
        `PTT_OFF_STATUS:
        begin
          next_state.rdata = {state.overflow_flag, state.overflow_irq_enable, state.counter_halt,
                              2'b00, state.prescale_select};
          if (state.overflow_flag && !protect)
          begin
            next_state.clear_armed = 1'b1;
          end
        end
        `PTT_OFF_CNT_HI:
        begin
          next_state.rdata = state.count[15:8];
          if (state.latch == PTT_LATCH_OPEN)
          begin
            next_state.low_latch = state.count[7:0];
            next_state.latch = PTT_LATCH_HELD;
          end
        end
        `PTT_OFF_CNT_LO:
        begin
          next_state.rdata = (state.latch == PTT_LATCH_HELD) ? state.low_latch : state.count[7:0];
          next_state.latch = PTT_LATCH_OPEN;
        end
        `PTT_OFF_WRAP_HI:
        begin
          next_state.rdata = state.wrap[15:8];
        end
        `PTT_OFF_WRAP_LO:
        begin
          next_state.rdata = state.wrap[7:0];
        end
        default:
        begin
          next_state.rdata = 8'h00;
        end
      endcase
    end
    // writes
    if (access && wr)
    begin
      case (addr)
        `PTT_OFF_STATUS:
        begin
          next_state.overflow_irq_enable = wdata[`PTT_BIT_IE];
          next_state.counter_halt = wdata[`PTT_BIT_HALT];
          next_state.prescale_select = wdata[`PTT_PS_HI:`PTT_PS_LO];
          // writing 1 to the flag is ignored; 0 clears only if armed
          if (!wdata[`PTT_BIT_OVF] && state.clear_armed && !protect)
          begin
            next_state.overflow_flag = 1'b0;
            next_state.clear_armed = 1'b0;
          end
        end
        `PTT_OFF_WRAP_HI:
        begin
          next_state.wrap_hi_buf = wdata;
          next_state.wrap_pending = 1'b1;
        end
        `PTT_OFF_WRAP_LO:
        begin
          next_state.wrap = {state.wrap_pending ? state.wrap_hi_buf : state.wrap[15:8], wdata};
          next_state.wrap_pending = 1'b0;
        end
        default:
        begin
          next_state.wrap_pending = state.wrap_pending;
        end
      endcase
    end
    // a new overflow wins over the clear and disarms it
    if (ovf_set)
    begin
      next_state.overflow_flag = 1'b1;
      next_state.clear_armed = 1'b0;
    end
    next_state.irq = next_state.overflow_flag && next_state.overflow_irq_enable
                     && !next_state.wrap_pending;
  end

  // all state in one register
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      state <= '0;
      state.wrap <= `PTT_WRAP_RESET;
      state.counter_halt <= 1'b1;
      state.prescale_select <= `PTT_PS_RESET;
      state.latch <= PTT_LATCH_OPEN;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign rdata = state.rdata;
  assign irq = state.irq;

  // halted counter moves only when cleared
  a_halt_holds: assert property (@(posedge clk) disable iff (!rstn)
    $past(state.counter_halt) && !$past(clear_req) |-> $stable(state.count))
    else $error("counter moved while halted");
  // break freezes count
  a_break_holds: assert property (@(posedge clk) disable iff (!rstn)
    $past(break_active) && !$past(clear_req) |-> $stable(state.count))
    else $error("counter moved in break");
  // stop freezes count
  a_stop_holds: assert property (@(posedge clk) disable iff (!rstn)
    $past(stop_mode) && !$past(clear_req) |-> $stable(state.count))
    else $error("counter moved in stop");
  // clear zeroes the counter next cycle
  a_clear_zero: assert property (@(posedge clk) disable iff (!rstn)
    clear_req |=> state.count == 16'h0000)
    else $error("counter clear failed");
  // overflow with no modulo write pending sets flag
  a_ovf_sets: assert property (@(posedge clk) disable iff (!rstn)
    ovf_set |=> state.overflow_flag)
    else $error("overflow flag not set");
  // wrap restart
  a_wrap_zero: assert property (@(posedge clk) disable iff (!rstn)
    hit |=> state.count == 16'h0000)
    else $error("count did not restart");
  // irq follows flag and enable
  a_irq_and: assert property (@(posedge clk) disable iff (!rstn)
    irq |-> state.overflow_flag && state.overflow_irq_enable)
    else $error("irq without enabled flag");
  // flag cannot drop without an armed clearing write
  a_flag_kept: assert property (@(posedge clk) disable iff (!rstn)
    $fell(state.overflow_flag) |-> $past(wr) && $past(state.clear_armed) && !$past(protect))
    else $error("flag cleared without sequence");
  // registers untouched in wait
  a_wait_locked: assert property (@(posedge clk) disable iff (!rstn)
    wait_mode && wr |=> $stable(state.wrap) && $stable(state.counter_halt) && $stable(state.overflow_irq_enable))
    else $error("write taken in wait");
  // clear bit reads as zero
  a_clr_reads0: assert property (@(posedge clk) disable iff (!rstn)
    $past(rd) && $past(addr) == `PTT_OFF_STATUS |-> !rdata[`PTT_BIT_CLR])
    else $error("clear bit read as one");

  // disabled interrupt never requests
  a_irq_needs_ie: assert property (@(posedge clk) disable iff (!rstn)
    !state.overflow_irq_enable |-> !irq)
    else $error("irq while disabled");

  // half-written modulo keeps the request quiet
  a_pending_no_irq: assert property (@(posedge clk) disable iff (!rstn)
    state.wrap_pending |-> !irq)
    else $error("irq while modulo pending");

  // flag only rises from a compare hit outside a pending modulo write
  a_flag_rise_src: assert property (@(posedge clk) disable iff (!rstn)
    $rose(state.overflow_flag) |-> $past(hit) && !$past(state.wrap_pending))
    else $error("flag rose without hit");

  // writing one to the flag leaves it set
  a_one_write_kept: assert property (@(posedge clk) disable iff (!rstn)
    access && wr && (addr == `PTT_OFF_STATUS) && wdata[`PTT_BIT_OVF] && state.overflow_flag
    |=> state.overflow_flag)
    else $error("flag dropped by a one write");

  // a fresh overflow disarms a half-done clear, so no request is lost
  a_ovf_disarms: assert property (@(posedge clk) disable iff (!rstn)
    ovf_set |=> state.overflow_flag && !state.clear_armed)
    else $error("overflow left clear armed");

  // protected break never drops the flag
  a_protect_keeps: assert property (@(posedge clk) disable iff (!rstn)
    protect && state.overflow_flag |=> state.overflow_flag)
    else $error("flag cleared in protected break");

  // protected break never arms a clear
  a_protect_no_arm: assert property (@(posedge clk) disable iff (!rstn)
    protect && !state.clear_armed |=> !state.clear_armed)
    else $error("clear armed in protected break");

  // arming from before the break survives it; counter is frozen so no overflow can disarm
  a_arm_survives: assert property (@(posedge clk) disable iff (!rstn)
    protect && state.clear_armed |=> state.clear_armed)
    else $error("arming lost in protected break");

  // one step per tick below the modulo value
  a_count_steps: assert property (@(posedge clk) disable iff (!rstn)
    tick && !clear_req && !hit |=> state.count == $past(state.count) + 16'h0001)
    else $error("count did not step");

  // no tick, no movement; reads of the count are not a cause
  a_count_idle: assert property (@(posedge clk) disable iff (!rstn)
    !tick && !clear_req |=> $stable(state.count))
    else $error("count moved without tick");

  // refused reads in wait answer zero
  a_wait_reads_zero: assert property (@(posedge clk) disable iff (!rstn)
    $past(rd) && $past(wait_mode) |-> rdata == 8'h00)
    else $error("read answered in wait");

  // read data stand only in the cycle after the strobe
  a_rdata_idle: assert property (@(posedge clk) disable iff (!rstn)
    !$past(rd) |-> rdata == 8'h00)
    else $error("read data without read");

  // held low byte is not recaptured by further high reads
  a_latch_holds: assert property (@(posedge clk) disable iff (!rstn)
    (state.latch == PTT_LATCH_HELD) && !(access && rd && (addr == `PTT_OFF_CNT_LO))
    |=> $stable(state.low_latch))
    else $error("latched low byte changed");

  // high read with open latch captures the low byte
  a_latch_takes: assert property (@(posedge clk) disable iff (!rstn)
    access && rd && (addr == `PTT_OFF_CNT_HI) && (state.latch == PTT_LATCH_OPEN)
    |=> state.low_latch == $past(state.count[7:0]))
    else $error("low byte not captured");

  // low read releases the latch
  a_latch_frees: assert property (@(posedge clk) disable iff (!rstn)
    access && rd && (addr == `PTT_OFF_CNT_LO) |=> state.latch == PTT_LATCH_OPEN)
    else $error("latch not released");

  // low write loads the modulo and ends the inhibit
  a_wrap_loads: assert property (@(posedge clk) disable iff (!rstn)
    access && wr && (addr == `PTT_OFF_WRAP_LO) |=> !state.wrap_pending && state.wrap[7:0] == $past(wdata))
    else $error("modulo low write not loaded");

  // high write is only buffered, so the compare never sees a torn value
  a_wrap_buffers: assert property (@(posedge clk) disable iff (!rstn)
    access && wr && (addr == `PTT_OFF_WRAP_HI) |=> state.wrap_pending && $stable(state.wrap))
    else $error("modulo high write not buffered");

  // status write sets the enable
  a_ie_written: assert property (@(posedge clk) disable iff (!rstn)
    access && wr && (addr == `PTT_OFF_STATUS) |=> state.overflow_irq_enable == $past(wdata[`PTT_BIT_IE]))
    else $error("enable not written");

  // status write sets the halt bit
  a_halt_written: assert property (@(posedge clk) disable iff (!rstn)
    access && wr && (addr == `PTT_OFF_STATUS) |=> state.counter_halt == $past(wdata[`PTT_BIT_HALT]))
    else $error("halt not written");

  // status write sets the prescale select
  a_select_written: assert property (@(posedge clk) disable iff (!rstn)
    access && wr && (addr == `PTT_OFF_STATUS)
    |=> state.prescale_select == $past(wdata[`PTT_PS_HI:`PTT_PS_LO]))
    else $error("select not written");
endmodule

/* test/ptt_cpu_model.sv */
// cpu bus master model driving the register port of the periodic tick timer
// assumes the timer answers a read in the cycle after the strobe, never stalls
`include "ptt_defs.svh"
`timescale 1ns/1ps
module ptt_cpu_model
(
  // clock
  input wire logic clk,
  // register port
  output logic [`PTT_ADDR_W-1:0] addr,
  output ptt_pkg::ptt_byte_t wdata,
  output logic wr,
  output logic rd,
  input wire ptt_pkg::ptt_byte_t rdata
);
  import ptt_pkg::*;
  // idle bus at time zero
  initial
  begin
    addr = 16'h0000;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end
  // one-cycle write, signals moved just after the edge
  task automatic wr_reg(input logic [15:0] a, input ptt_byte_t d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // one-cycle read; data sampled mid-cycle so the registered answer has landed
  task automatic rd_reg(input logic [15:0] a, output ptt_byte_t d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask
endmodule

/* test/ptt_timer_tb.sv */
// self-checking bench for the periodic tick timer through its register port
// assumes ptt_cpu_model as bus master; small wrap values keep runs short
`include "ptt_defs.svh"
`timescale 1ns/1ps
module ptt_timer_tb;
  import ptt_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic wait_mode = 1'b0;
  logic stop_mode = 1'b0;
  logic break_active = 1'b0;
  logic break_clear_enable = 1'b0;
  logic [15:0] addr;
  ptt_byte_t wdata;
  ptt_byte_t rdata;
  ptt_byte_t v;
  logic wr;
  logic rd;
  logic irq;
  ptt_word_t w;
  ptt_word_t w2;
  ptt_word_t e;
  int n_errors = 0;
  int check_count = 0;
  // 40 MHz bus clock
  always #12.5 clk = ~clk;
  ptt_cpu_model cpu_u (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  ptt_timer dut_u (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .wait_mode(wait_mode), .stop_mode(stop_mode), .break_active(break_active),
    .break_clear_enable(break_clear_enable), .irq(irq));
  // comparisons
  task automatic chk8(input string what, input ptt_byte_t exp, input ptt_byte_t got);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk1(input string what, input logic exp, input logic got);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic ticks(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic st(input ptt_byte_t d);
    cpu_u.wr_reg(`PTT_OFF_STATUS, d);
  endtask
  task automatic rd_st(input ptt_byte_t exp);
    cpu_u.rd_reg(`PTT_OFF_STATUS, v);
    chk8("status", exp, v);
  endtask
  // high byte first, so the low byte comes from the latch
  task automatic rd_cnt(output ptt_word_t c);
    cpu_u.rd_reg(`PTT_OFF_CNT_HI, c[15:8]);
    cpu_u.rd_reg(`PTT_OFF_CNT_LO, c[7:0]);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // watchdog, well beyond the roughly 2400 cycles the tests take
  initial
  begin
    #(25 * 20000);
    n_errors++;
    test_done;
  end
  initial
  begin
    ticks(16);
    rstn <= 1'b1;
    rd_st(8'h20);
    cpu_u.rd_reg(`PTT_OFF_WRAP_HI, v);
    chk8("wrap high", 8'hFF, v);
    cpu_u.rd_reg(`PTT_OFF_WRAP_LO, v);
    chk8("wrap low", 8'hFF, v);
    rd_cnt(w);
    chk1("count at reset", 1'b1, w === 16'h0000);
    cpu_u.rd_reg(16'h0050, v);
    chk8("unmapped", 8'h00, v);
    chk1("irq", 1'b0, irq);
    $display("test reset done");
    // every select code, clear and run, then halt after 256 bus cycles
    for (int s = 0; s < 8; s++)
    begin
      st(8'h10 | 8'(s));
      ticks(256);
      st(8'h20 | 8'(s));
      rd_cnt(w);
      e = 16'd256 >> (s == 7 ? 6 : s);
      chk1("prescaled count", 1'b1, w + 2 >= e && w <= e + 2);
    end
    rd_st(8'h27);
    $display("test prescale done");
    // latch survives counting between the two byte reads
    cpu_u.rd_reg(`PTT_OFF_CNT_HI, v);
    st(8'h00);
    ticks(20);
    st(8'h20);
    cpu_u.rd_reg(`PTT_OFF_CNT_LO, v);
    chk8("latched low", w[7:0], v);
    rd_cnt(w2);
    chk1("count moved", 1'b1, w2 > w + 16 && w2 < w + 30);
    $display("test latch done");
    // wrap at 5; a pending high write holds the flag back
    st(8'h30);
    cpu_u.wr_reg(`PTT_OFF_WRAP_HI, 8'h00);
    cpu_u.wr_reg(`PTT_OFF_WRAP_LO, 8'h05);
    cpu_u.wr_reg(`PTT_OFF_WRAP_HI, 8'h00);
    st(8'h40);
    ticks(20);
    chk1("irq held back", 1'b0, irq);
    rd_st(8'h40);
    cpu_u.wr_reg(`PTT_OFF_WRAP_LO, 8'h05);
    ticks(20);
    chk1("irq", 1'b1, irq);
    st(8'hE0);
    rd_cnt(w);
    chk1("count within wrap", 1'b1, w <= 16'h0005);
    st(8'h60);
    rd_st(8'hE0);
    st(8'h60);
    rd_st(8'h60);
    chk1("irq", 1'b0, irq);
    st(8'h00);
    ticks(20);
    chk1("irq disabled", 1'b0, irq);
    rd_st(8'h80);
    ticks(10);
    st(8'h00);
    rd_st(8'h80);
    st(8'hA0);
    $display("test overflow done");
    // armed before a protected break, cleared after it
    rd_st(8'hA0);
    @(posedge clk) break_active <= 1'b1;
    st(8'h20);
    rd_st(8'hA0);
    @(posedge clk) break_active <= 1'b0;
    st(8'h20);
    rd_st(8'h20);
    st(8'h00);
    ticks(10);
    st(8'hA0);
    @(posedge clk) break_active <= 1'b1;
    break_clear_enable <= 1'b1;
    rd_st(8'hA0);
    st(8'h20);
    rd_st(8'h20);
    @(posedge clk) break_active <= 1'b0;
    break_clear_enable <= 1'b0;
    rd_st(8'h20);
    $display("test break flags done");
    // break, then stop, freeze the running count
    for (int m = 0; m < 2; m++)
    begin
      st(8'h00);
      @(posedge clk) break_active <= (m == 0);
      stop_mode <= (m == 1);
      ticks(2);
      rd_cnt(w);
      ticks(21);
      rd_cnt(w2);
      chk1("count frozen", 1'b1, w2 === w);
      @(posedge clk) break_active <= 1'b0;
      stop_mode <= 1'b0;
      st(8'h20);
    end
    $display("test freeze done");
    // wait mode: still counting, wakes by irq, bus refused
    rd_st(8'hA0);
    st(8'h20);
    st(8'h40);
    @(posedge clk) wait_mode <= 1'b1;
    ticks(20);
    chk1("wake irq", 1'b1, irq);
    st(8'h20);
    rd_st(8'h00);
    @(posedge clk) wait_mode <= 1'b0;
    rd_st(8'hC0);
    st(8'hE0);
    $display("test wait done");
    test_done;
  end
endmodule
